// file: design/prwg_map.vh
// Address map and field constants for the protected register write gate.
// Assumes 16-bit word addressing on a 22-bit CPU data address.
`ifndef PRWG_MAP_VH
`define PRWG_MAP_VH

`define PRWG_AW 22
// Frame 0 protected windows
`define PRWG_DEVCFG_LO 22'h00_0880
`define PRWG_DEVCFG_HI 22'h00_0881
`define PRWG_BPSTART 22'h00_0884
`define PRWG_BPRANGE 22'h00_0885
`define PRWG_EMU_LO 22'h00_0880
`define PRWG_EMU_HI 22'h00_09FF
`define PRWG_FLASH_LO 22'h00_0A80
`define PRWG_FLASH_HI 22'h00_0A87
`define PRWG_FLREG_HI 22'h00_0ADF
`define PRWG_CSU_LO 22'h00_0AE0
`define PRWG_CSU_HI 22'h00_0AEF
`define PRWG_VEC_LO 22'h00_0D00
`define PRWG_VEC_HI 22'h00_0DFF
`define PRWG_DMA_LO 22'h00_1000
`define PRWG_DMA_HI 22'h00_11FF
`define PRWG_XINTF_LO 22'h00_0B20
`define PRWG_XINTF_HI 22'h00_0B3F
`define PRWG_F0_LO 22'h00_0000
`define PRWG_F0_HI 22'h00_1FFF
// Frame 1
`define PRWG_F1_LO 22'h00_6000
`define PRWG_F1_HI 22'h00_6FFF
`define PRWG_PWM1_LO 22'h00_6800
`define PRWG_PWM1_HI 22'h00_697F
`define PRWG_GPCTL_LO 22'h00_6F80
`define PRWG_GPCTL_HI 22'h00_6FBF
`define PRWG_GPWAKE_LO 22'h00_6FE0
`define PRWG_GPWAKE_HI 22'h00_6FFF
// Frame 2
`define PRWG_F2_LO 22'h00_7000
`define PRWG_F2_HI 22'h00_7FFF
`define PRWG_SYSCTL_LO 22'h00_7010
`define PRWG_SYSCTL_HI 22'h00_702F
`define PRWG_MAPCFG_ADDR 22'h00_702E
// Frame 3
`define PRWG_F3_LO 22'h00_5000
`define PRWG_F3_HI 22'h00_5FFF
`define PRWG_PWM3_LO 22'h00_5800
`define PRWG_PWM3_HI 22'h00_597F
// Map register
`define PRWG_REMAP_BIT 0
`define PRWG_MAPCFG_RST 16'h0000
`define PRWG_ZERO16 16'h0000
`define PRWG_ZERO32 32'h0000_0000

`endif

// file: design/prwg_region_decode.v
// Address region decoder for the protected register write gate.
// Assumes a word address that is stable during the access cycle.
`timescale 1ns/1ps
`include "prwg_map.vh"

module prwg_region_decode #(
	parameter AW = `PRWG_AW
)
(
	input wire [AW-1:0] addr,
	input wire pwm_dma_remap_bit,
	output reg in_frame0,
	output reg in_frame1,
	output reg in_frame2,
	output reg in_frame3,
	output reg pwm_hit,
	output reg prot_hit,
	output reg flash_hit
);
	function in_rng;
		input [AW-1:0] a;
		input [AW-1:0] lo;
		input [AW-1:0] hi;
		begin
			in_rng = (a >= lo) && (a <= hi);
		end
	endfunction

	reg pwm_f1;
	reg pwm_f3;

	always @*
	begin
		pwm_f1 = in_rng(addr, `PRWG_PWM1_LO, `PRWG_PWM1_HI);
		pwm_f3 = in_rng(addr, `PRWG_PWM3_LO, `PRWG_PWM3_HI);
		// PWM window follows the remap bit; the idle copy decodes to nothing
		pwm_hit = pwm_dma_remap_bit ? pwm_f3 : pwm_f1;
		in_frame0 = in_rng(addr, `PRWG_F0_LO, `PRWG_F0_HI);
		in_frame1 = in_rng(addr, `PRWG_F1_LO, `PRWG_F1_HI) && !(pwm_f1 && pwm_dma_remap_bit);
		in_frame3 = in_rng(addr, `PRWG_F3_LO, `PRWG_F3_HI) && !(pwm_f3 && !pwm_dma_remap_bit);
		in_frame2 = in_rng(addr, `PRWG_F2_LO, `PRWG_F2_HI);
		flash_hit = in_rng(addr, `PRWG_FLASH_LO, `PRWG_FLREG_HI);
		prot_hit = in_rng(addr, `PRWG_EMU_LO, `PRWG_EMU_HI)
			|| in_rng(addr, `PRWG_FLASH_LO, `PRWG_FLASH_HI)
			|| flash_hit
			|| in_rng(addr, `PRWG_CSU_LO, `PRWG_CSU_HI)
			|| in_rng(addr, `PRWG_VEC_LO, `PRWG_VEC_HI)
			|| in_rng(addr, `PRWG_DMA_LO, `PRWG_DMA_HI)
			|| in_rng(addr, `PRWG_XINTF_LO, `PRWG_XINTF_HI)
			|| in_rng(addr, `PRWG_GPCTL_LO, `PRWG_GPCTL_HI)
			|| in_rng(addr, `PRWG_GPWAKE_LO, `PRWG_GPWAKE_HI)
			|| in_rng(addr, `PRWG_SYSCTL_LO, `PRWG_SYSCTL_HI);
	end
endmodule

// file: design/prwg_gate.v
// Write-protection and access-width gate in front of the peripheral frames.
// Assumes one CPU and one debug requester, single-cycle accesses, and
// word addressing; the CPU signals unlock and relock instructions as pulses.
//
// Function
// - Frame 0/1 accept 16 and 32-bit accesses; 32-bit ones use even addresses.
// - Frame 2 takes only 16-bit accesses; 32-bit ones are dropped.
// - Protected CPU writes do nothing until the unlock instruction sets the flag.
// - The relock instruction clears the write-unlock flag again.
// - Flash configuration writes also need the security unit unlocked.
// - GPIO interrupt and wakeup select words 0x6FE0-0x6FFF are protected.
// - Map register bit 0 moves the PWM modules into frame 3.
// - With remap bit clear the PWM modules decode in frame 1.
// - Remapped PWM instances sit at 0x5800-0x597F, 64 words each.
// - The map register itself is write-protected.
// - With flag clear, protected CPU writes are discarded silently.
// - CPU reads and debug reads and writes are never blocked by write protection; bad-width ones are still dropped.
// - Debug-port accesses bypass the write-unlock flag.
// - Reset clears the write-unlock flag.
// - With flag set, protected CPU writes pass, except flash ones while the security unit is locked.
// - Device configuration pair and block-protect registers are protected.
// - Flash and OTP configuration words 0x0A80-0x0A87 are protected.
`timescale 1ns/1ps
`include "prwg_map.vh"

module prwg_gate #(
	parameter AW = `PRWG_AW
)
(
	input wire sys_clk,
	input wire rst,
	input wire unlock_instr,
	input wire relock_instr,
	input wire code_security_locked,
	input wire cpu_req,
	input wire cpu_we,
	input wire cpu_wide,
	input wire [AW-1:0] cpu_addr,
	input wire [31:0] cpu_wdata,
	input wire dbg_req,
	input wire dbg_we,
	input wire dbg_wide,
	input wire [AW-1:0] dbg_addr,
	input wire [31:0] dbg_wdata,
	input wire [31:0] periph_rdata,
	output wire dbg_grant,
	output wire cpu_grant,
	output wire periph_req,
	output wire periph_we,
	output wire periph_wide,
	output wire [AW-1:0] periph_addr,
	output wire [31:0] periph_wdata,
	output wire periph_sel_f0,
	output wire periph_sel_f1,
	output wire periph_sel_f2,
	output wire periph_sel_f3,
	output wire periph_sel_pwm,
	output reg [31:0] rdata,
	output reg rvalid,
	output wire write_unlock_flag,
	output wire pwm_dma_remap_bit,
	output wire [15:0] bus_frame_map_config
);
	// ==========================================
	// State
	// ==========================================
	reg unlock_reg;
	reg unlock_next;
	reg [15:0] map_reg;
	reg [15:0] map_next;
	reg [31:0] rdata_next;
	reg rvalid_next;

	// ==========================================
	// Requester selection
	// ==========================================
	// Debug wins the cycle so halted-core inspection never waits on the CPU
	wire use_dbg = dbg_req;
	wire [AW-1:0] a = use_dbg ? dbg_addr : cpu_addr;
	wire we = use_dbg ? dbg_we : cpu_we;
	wire wide = use_dbg ? dbg_wide : cpu_wide;
	wire [31:0] wd = use_dbg ? dbg_wdata : cpu_wdata;
	wire req = dbg_req | cpu_req;

	assign dbg_grant = dbg_req;
	assign cpu_grant = cpu_req & ~dbg_req;

	wire f0;
	wire f1;
	wire f2;
	wire f3;
	wire pwm;
	wire prot;
	wire flash;

	prwg_region_decode #(
		.AW(AW)
	)
	u_dec
	(
		.addr(a),
		.pwm_dma_remap_bit(map_reg[`PRWG_REMAP_BIT]),
		.in_frame0(f0),
		.in_frame1(f1),
		.in_frame2(f2),
		.in_frame3(f3),
		.pwm_hit(pwm),
		.prot_hit(prot),
		.flash_hit(flash)
	);

	// ==========================================
	// Access checks
	// ==========================================
	// Wide access must be word-pair aligned in frames 0/1 and never reach frame 2
	wire misalign = wide & a[0];
	wire wide_bad = wide & f2;
	wire width_ok = ~misalign & ~wide_bad;

	// Debug side ignores the flag; flash also needs the security unit open
	wire cpu_wr_ok = ~prot | (unlock_reg & ~(flash & code_security_locked));
	wire wr_ok = use_dbg | cpu_wr_ok;
	// Reads always pass the protection check
	wire pass = req & width_ok & (~we | wr_ok);

	wire map_hit = (a == `PRWG_MAPCFG_ADDR);

	assign periph_req = pass & ~map_hit;
	assign periph_we = we;
	assign periph_wide = wide;
	assign periph_addr = a;
	assign periph_wdata = wd;
	assign periph_sel_f0 = f0;
	assign periph_sel_f1 = f1 & ~pwm;
	assign periph_sel_f2 = f2;
	assign periph_sel_f3 = f3 & ~pwm;
	assign periph_sel_pwm = pwm;

	assign write_unlock_flag = unlock_reg;
	assign pwm_dma_remap_bit = map_reg[`PRWG_REMAP_BIT];
	assign bus_frame_map_config = map_reg;

	// ==========================================
	// Next-state logic
	// ==========================================
	always @*
	begin
		unlock_next = unlock_reg;
		if (unlock_instr)
		begin
			unlock_next = 1'b1;
		end
		else if (relock_instr)
		begin
			unlock_next = 1'b0;
		end

		map_next = map_reg;
		if (pass & we & map_hit)
		begin
			map_next = wd[15:0];
		end

		// Blocked writes still complete silently with no error flag
		rvalid_next = req & ~we;
		rdata_next = `PRWG_ZERO32;
		if (req & ~we & width_ok)
		begin
			rdata_next = map_hit ? {`PRWG_ZERO16, map_reg} : periph_rdata;
		end
	end

	// ==========================================
	// Registers
	// ==========================================
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			unlock_reg <= 1'b0;
			map_reg <= `PRWG_MAPCFG_RST;
			rdata <= `PRWG_ZERO32;
			rvalid <= 1'b0;
		end
		else
		begin
			unlock_reg <= unlock_next;
			map_reg <= map_next;
			rdata <= rdata_next;
			rvalid <= rvalid_next;
		end
	end
endmodule

// file: verif/prwg_gate_props.sv
// Checker for the write gate, bound to prwg_gate.
// Assumes word addressing and the map register at word 0x702E.
`timescale 1ns/1ps
module prwg_props(
	input wire sys_clk,
	input wire rst,
	input wire unlock_instr,
	input wire relock_instr,
	input wire cpu_we,
	input wire cpu_wide,
	input wire [21:0] cpu_addr,
	input wire cpu_grant,
	input wire periph_req,
	input wire rvalid,
	input wire write_unlock_flag,
	input wire pwm_dma_remap_bit
);
// ==========================================
// Properties
default clocking @(posedge sys_clk); endclocking
default disable iff (rst);
wire wake = cpu_addr >= 22'h00_6FE0 && cpu_addr <= 22'h00_6FFF;
wire wr = cpu_grant && cpu_we;
AST_UNLOCK: assert property (unlock_instr |=> write_unlock_flag)
	else $error("flag not set");
AST_RELOCK: assert property (relock_instr && !unlock_instr |=> !write_unlock_flag)
	else $error("flag not cleared");
AST_WAKE_BLOCK: assert property (wr && wake && !write_unlock_flag |-> !periph_req)
	else $error("locked write passed");
AST_WAKE_PASS: assert property (wr && !cpu_wide && wake && write_unlock_flag |-> periph_req)
	else $error("unlocked write dropped");
AST_READ: assert property (cpu_grant && !cpu_we |=> rvalid)
	else $error("read not answered");
AST_ODD: assert property (cpu_grant && cpu_wide && cpu_addr[0] |-> !periph_req)
	else $error("odd wide access passed");
AST_F2_WIDE: assert property (cpu_grant && cpu_wide && cpu_addr[21:12] == 10'h007 |-> !periph_req)
	else $error("wide frame 2 access passed");
AST_MAP_LOCK: assert property (wr && cpu_addr == 22'h00_702E && !write_unlock_flag
	|=> $stable(pwm_dma_remap_bit))
	else $error("locked map write took effect");
endmodule
bind prwg_gate prwg_props u_prwg_props(.sys_clk, .rst, .unlock_instr, .relock_instr,
	.cpu_we, .cpu_wide, .cpu_addr, .cpu_grant, .periph_req, .rvalid,
	.write_unlock_flag, .pwm_dma_remap_bit);

// file: verif/prwg_periph_model.sv
// Peripheral side: answers reads with a word built from the address.
// Assumes combinational read data, as the gate expects.
`timescale 1ns/1ps
module prwg_periph_model(
	input wire periph_req,
	input wire periph_we,
	input wire [21:0] periph_addr,
	output wire [31:0] periph_rdata
);
// Inverse when not read, so a stale value can never pass for an answer
assign periph_rdata = (periph_req && !periph_we) ? {10'h000, periph_addr} : ~{10'h000, periph_addr};
endmodule

// file: verif/tb_prwg_gate.sv
// Testbench for prwg_gate: CPU and debug accesses, map register, widths.
// Assumes the peripheral model answers reads in the same cycle.
`timescale 1ns/1ps
module tb_prwg_gate;
reg sys_clk = 0, rst = 1, ul = 0, rl = 0, csl = 1, rc = 0, rd_ = 0, we = 0, wide = 0;
reg [21:0] a = 22'h00_0000;
reg [31:0] wd = 32'h0000_0000;
wire pr, pw, flag, remap, rv, spwm;
wire cg, dg, pwide, sf0, sf1, sf2, sf3;
wire [31:0] pwd;
wire [21:0] pa;
wire [31:0] prd, rdata;
wire [15:0] map;
integer fail_count = 0, n_tests = 0, cyc = 0, seed = 32'h29f3, i;
logic [21:0] pq [5] = '{22'h00_0880, 22'h00_0884, 22'h00_0885, 22'h00_0A87, 22'h00_6FFF};
prwg_gate u_prwg_gate(.sys_clk(sys_clk), .rst(rst), .unlock_instr(ul), .relock_instr(rl),
	.code_security_locked(csl), .cpu_req(rc), .cpu_we(we), .cpu_wide(wide), .cpu_addr(a),
	.cpu_wdata(wd), .dbg_req(rd_), .dbg_we(we), .dbg_wide(wide), .dbg_addr(a), .dbg_wdata(wd),
	.periph_rdata(prd), .dbg_grant(dg), .cpu_grant(cg), .periph_req(pr), .periph_we(pw),
	.periph_wide(pwide), .periph_addr(pa), .periph_wdata(pwd), .periph_sel_f0(sf0),
	.periph_sel_f1(sf1), .periph_sel_f2(sf2), .periph_sel_f3(sf3), .periph_sel_pwm(spwm),
	.rdata(rdata), .rvalid(rv),
	.write_unlock_flag(flag), .pwm_dma_remap_bit(remap), .bus_frame_map_config(map));
prwg_periph_model u_prwg_periph_model(.periph_req(pr), .periph_we(pw), .periph_addr(pa),
	.periph_rdata(prd));
initial forever #25 sys_clk = ~sys_clk;
always @(posedge sys_clk)
begin
	cyc = cyc + 1;
	if (cyc > 2000)
	begin
		fail_count = fail_count + 1;
		final_report;
	end
end
// ==========================================
// Tasks
function [31:0] mdl(input [21:0] x);
	mdl = {10'h000, x};
endfunction
// Expected selects {pwm, f3, f2, f1, f0}; the idle PWM copy selects nothing
function [4:0] sel_exp(input [21:0] x, input r);
	reg p1, p3;
	p1 = (x >= 22'h00_6800) && (x <= 22'h00_697F);
	p3 = (x >= 22'h00_5800) && (x <= 22'h00_597F);
	sel_exp[0] = x <= 22'h00_1FFF;
	sel_exp[1] = (x[21:12] == 10'h006) && !p1;
	sel_exp[2] = x[21:12] == 10'h007;
	sel_exp[3] = (x[21:12] == 10'h005) && !p3;
	sel_exp[4] = r ? p3 : p1;
endfunction
task chk(input [31:0] got, input [31:0] exp);
	n_tests = n_tests + 1;
	if (got !== exp)
	begin
		fail_count = fail_count + 1;
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
	end
endtask
// Request stays up until the next call, so accesses run back to back
task op(input d, input w, input wi, input [21:0] ad, input [31:0] dt, input e);
	@(negedge sys_clk);
	rc = !d; rd_ = d; we = w; wide = wi; a = ad; wd = dt;
	#1 chk(pr, e);
	chk({cg, dg}, {!d, d});
	chk({pw, pwide, pa}, {w, wi, ad});
	chk(pwd, dt);
	chk({spwm, sf3, sf2, sf1, sf0}, sel_exp(ad, remap));
endtask
task rd(input [21:0] ad, input e, input [31:0] exp);
	op(0, 0, 0, ad, $random(seed), e);
	@(posedge sys_clk) #1;
	chk(rv, 1);
	chk(rdata, exp);
endtask
task pulse(input u, input s);
	@(negedge sys_clk);
	rc = 0; rd_ = 0; ul = u; rl = !u; csl = s;
	@(negedge sys_clk);
	ul = 0; rl = 0;
endtask
task final_report;
	$display("checks %0d mismatches %0d", n_tests, fail_count);
	if (fail_count == 0 && n_tests > 0)
		$display("Testbench passed");
	else
		$display("Testbench failed");
	$finish;
endtask
// ==========================================
// Sequence
initial
begin
	repeat (16) @(posedge sys_clk);
	@(negedge sys_clk) rst = 0;
	chk(flag, 0);
	chk(map, 0);
	$display("test done: reset");
	for (i = 0; i < 8; i = i + 1)
		op(0, 1, 0, 22'h00_6FE0 + ($random(seed) & 31), $random(seed), 0);
	op(0, 1, 0, 22'h00_702E, 1, 0);
	rd(22'h00_702E, 0, 0);
	rd(22'h00_0A80, 1, mdl(22'h00_0A80));
	op(1, 1, 0, 22'h00_6FE0, $random(seed), 1);
	$display("test done: locked");
	pulse(1, 0);
	chk(flag, 1);
	for (i = 0; i < 5; i = i + 1)
		op(0, 1, 0, pq[i], $random(seed), 1);
	pulse(1, 1);
	op(0, 1, 0, 22'h00_0A82, $random(seed), 0);
	op(0, 1, 0, 22'h00_702E, 1, 0);
	rd(22'h00_5800, 1, mdl(22'h00_5800));
	chk(remap, 1);
	chk(spwm, 1);
	op(0, 0, 0, 22'h00_6800, 0, 1);
	op(0, 1, 0, 22'h00_702E, 0, 0);
	rd(22'h00_6800, 1, mdl(22'h00_6800));
	chk(spwm, 1);
	$display("test done: unlocked");
	op(0, 0, 1, 22'h00_6001, 0, 0);
	op(0, 0, 1, 22'h00_6000, 0, 1);
	op(0, 0, 1, 22'h00_7040, 0, 0);
	op(0, 0, 0, 22'h00_7040, 0, 1);
	pulse(0, 1);
	chk(flag, 0);
	op(0, 1, 0, 22'h00_0884, $random(seed), 0);
	$display("test done: widths and relock");
	// Reset in mid-run must drop both the flag and the map register
	pulse(1, 1);
	op(0, 1, 0, 22'h00_702E, 1, 0);
	@(negedge sys_clk);
	chk(map, 1);
	rc = 0;
	rst = 1;
	@(negedge sys_clk);
	rst = 0;
	chk(flag, 0);
	chk(map, 0);
	$display("test done: mid-run reset");
	@(negedge sys_clk);
	rc = 0;
	final_report;
end
endmodule
